//--- design/uepr_pkg.sv
// Constants for the endpoint register interface of a low-speed USB function.
// Assumes an 8-bit processor I/O port and an 8-bit data memory port.
package uepr_pkg;
  // ----------------------------------------------------------------
  // I/O register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DEV_ADDR   = 8'h10;
  localparam logic [7:0] ADDR_CTL_COUNT  = 8'h11;
  localparam logic [7:0] ADDR_CTL_MODE   = 8'h12;
  localparam logic [7:0] ADDR_EP1_COUNT  = 8'h13;
  localparam logic [7:0] ADDR_EP1_MODE   = 8'h14;
  localparam logic [7:0] ADDR_EP2_COUNT  = 8'h15;
  localparam logic [7:0] ADDR_EP2_MODE   = 8'h16;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_SETUP   = 7;
  localparam int BIT_IN      = 6;
  localparam int BIT_OUT     = 5;
  localparam int BIT_ACK     = 4;
  localparam int BIT_TOGGLE  = 7;
  localparam int BIT_VALID   = 6;
  localparam int BIT_ADDR_EN = 7;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] DATA_EP_MODE_M = 8'h1F;
  localparam logic [3:0] MAX_IN_BYTES   = 4'h8;
  // ----------------------------------------------------------------
  // Buffer regions in data memory
  // ----------------------------------------------------------------
  localparam logic [7:0] BUF_A_LO = 8'hE0;
  localparam logic [7:0] BUF_A_HI = 8'hE7;
  localparam logic [7:0] BUF_B_LO = 8'hF8;
  localparam logic [7:0] BUF_B_HI = 8'hFF;
  localparam int NUM_EP    = 3;
  localparam int BUF_BYTES = 8;
endpackage : uepr_pkg

//--- design/uepr_regs.sv
// Endpoint register file, address register and endpoint buffers.
// Assumes synchronous I/O and memory strobes and an engine that reports
// token and ACK events as one-cycle pulses per endpoint.
`timescale 1ns/1ps
module uepr_regs #(
  parameter int NUM_EP    = uepr_pkg::NUM_EP,
  parameter int BUF_BYTES = uepr_pkg::BUF_BYTES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // Processor I/O port
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // Processor data memory writes toward buffers
  input  wire logic        mem_wr_valid,
  output logic             mem_wr_ready,
  input  wire logic [7:0]  mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_wr_blocked,
  // Engine side
  input  wire logic        sie_bus_reset,
  input  wire logic        sie_setup_data,
  input  wire logic        sie_ack_start,
  input  wire logic [2:0]  sie_ack_done,
  input  wire logic [2:0]  sie_tok_setup,
  input  wire logic [2:0]  sie_tok_in,
  input  wire logic [2:0]  sie_tok_out,
  input  wire logic [2:0]  sie_rx_valid,
  input  wire logic [2:0]  sie_buf_rd,
  input  wire logic [4:0]  sie_buf_rd_addr,
  output logic      [7:0]  sie_buf_rd_data,
  output logic             sie_addr_en,
  output logic      [6:0]  sie_dev_addr,
  output logic      [11:0] sie_mode,
  output logic      [11:0] sie_in_count,
  output logic      [2:0]  sie_toggle
);
  // Refused at elaboration: decode and buffer slots are laid out for 3 x 8 only
  if (NUM_EP != 3 || BUF_BYTES != 8)
  begin : g_bad_size
    $error("uepr_regs supports three endpoints of eight bytes only");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // True inside either setup-guarded buffer region; used by buffer write and the blocked flag
  function automatic logic hit_setup_guard(input logic [7:0] a);
    hit_setup_guard = (a >= uepr_pkg::BUF_A_LO && a <= uepr_pkg::BUF_A_HI) ||
                      (a >= uepr_pkg::BUF_B_LO && a <= uepr_pkg::BUF_B_HI);
  endfunction : hit_setup_guard

  function automatic logic [1:0] buf_slot(input logic [7:0] a);
    if (a >= uepr_pkg::BUF_B_LO)
      buf_slot = 2'h0;
    else if (a >= 8'hF0)
      buf_slot = 2'h1;
    else if (a >= 8'hE8)
      buf_slot = 2'h2;
    else if (a >= uepr_pkg::BUF_A_LO)
      buf_slot = 2'h3;
    else
      buf_slot = 2'h3;
  endfunction : buf_slot

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] addr_q, addr_d;
  logic [7:0] mode_q [3], mode_d [3];
  logic [7:0] cnt_q  [3], cnt_d  [3];
  logic       lock_q, lock_d;   // Low seven bits of control mode locked
  logic       hold_q, hold_d;   // Setup flag clear refused
  logic       fwin_q, fwin_d;   // Setup data phase in progress
  logic [7:0] rdata_q, rdata_d;

  // Next-state for registers; engine events take precedence over writes
  always_comb
  begin
    addr_d  = addr_q;
    lock_d  = lock_q;
    hold_d  = hold_q;
    fwin_d  = fwin_q;
    rdata_d = uepr_pkg::REG_RESET;
    for (int e = 0; e < 3; e++)
    begin
      mode_d[e] = mode_q[e];
      cnt_d[e]  = cnt_q[e];
    end
    // Firmware writes; lock only guards the control mode register
    if (io_wr)
    begin
      if (io_addr == uepr_pkg::ADDR_DEV_ADDR)
        addr_d = io_wdata;
      else if (io_addr == uepr_pkg::ADDR_CTL_COUNT)
        cnt_d[0] = io_wdata;
      else if (io_addr == uepr_pkg::ADDR_CTL_MODE)
      begin
        if (!lock_q)
          mode_d[0][6:0] = io_wdata[6:0];
        if (!(hold_q || fwin_q) || io_wdata[uepr_pkg::BIT_SETUP])
          mode_d[0][uepr_pkg::BIT_SETUP] = io_wdata[uepr_pkg::BIT_SETUP];
      end
      else if (io_addr == uepr_pkg::ADDR_EP1_COUNT)
        cnt_d[1] = io_wdata;
      else if (io_addr == uepr_pkg::ADDR_EP1_MODE)
        mode_d[1] = io_wdata & uepr_pkg::DATA_EP_MODE_M;
      else if (io_addr == uepr_pkg::ADDR_EP2_COUNT)
        cnt_d[2] = io_wdata;
      else if (io_addr == uepr_pkg::ADDR_EP2_MODE)
        mode_d[2] = io_wdata & uepr_pkg::DATA_EP_MODE_M;
    end
    // Reads return state; a control mode read releases the control endpoint locks
    if (io_rd)
    begin
      if (io_addr == uepr_pkg::ADDR_DEV_ADDR)
        rdata_d = addr_q;
      else if (io_addr == uepr_pkg::ADDR_CTL_COUNT)
        rdata_d = cnt_q[0];
      else if (io_addr == uepr_pkg::ADDR_CTL_MODE)
      begin
        rdata_d = mode_q[0];
        lock_d = 1'b0;
        hold_d = 1'b0;
      end
      else if (io_addr == uepr_pkg::ADDR_EP1_COUNT)
        rdata_d = cnt_q[1];
      else if (io_addr == uepr_pkg::ADDR_EP1_MODE)
        rdata_d = mode_q[1];
      else if (io_addr == uepr_pkg::ADDR_EP2_COUNT)
        rdata_d = cnt_q[2];
      else if (io_addr == uepr_pkg::ADDR_EP2_MODE)
        rdata_d = mode_q[2];
    end
    if (sie_setup_data)
      fwin_d = 1'b1;
    if (sie_ack_start)
    begin
      fwin_d = 1'b0;
      hold_d = 1'b1;
    end
    if (fwin_q || sie_setup_data)
      mode_d[0][uepr_pkg::BIT_SETUP] = 1'b1;
    for (int e = 0; e < 3; e++)
    begin
      if (sie_ack_done[e])
        mode_d[e][uepr_pkg::BIT_ACK] = 1'b1;
      if (sie_tok_setup[e] || sie_tok_out[e])
        cnt_d[e][uepr_pkg::BIT_VALID] = sie_rx_valid[e];
    end
    if (sie_tok_setup[0])
      mode_d[0][uepr_pkg::BIT_SETUP] = 1'b1;
    if (sie_tok_in[0])
      mode_d[0][uepr_pkg::BIT_IN] = 1'b1;
    if (sie_tok_out[0])
      mode_d[0][uepr_pkg::BIT_OUT] = 1'b1;
    // Engine touch of low bits arms the write lock until the next control mode read
    if (sie_ack_done[0] || sie_tok_in[0] || sie_tok_out[0])
      lock_d = 1'b1;
    if (sie_bus_reset)
      addr_d = uepr_pkg::REG_RESET;
  end

  // Register stage; clock enable freezes everything
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      addr_q  <= uepr_pkg::REG_RESET;
      lock_q  <= 1'b0;
      hold_q  <= 1'b0;
      fwin_q  <= 1'b0;
      rdata_q <= uepr_pkg::REG_RESET;
      for (int e = 0; e < 3; e++)
      begin
        mode_q[e] <= uepr_pkg::REG_RESET;
        cnt_q[e]  <= uepr_pkg::REG_RESET;
      end
    end
    else if (clk_en)
    begin
      addr_q  <= addr_d;
      lock_q  <= lock_d;
      hold_q  <= hold_d;
      fwin_q  <= fwin_d;
      rdata_q <= rdata_d;
      mode_q  <= mode_d;
      cnt_q   <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Two-entry write buffer in front of endpoint memory
  // ----------------------------------------------------------------
  // Skid storage so a stalled memory port drops no write
  logic [15:0] fifo_q [2], fifo_d [2];
  logic [1:0]  cnt_f_q, cnt_f_d;
  logic        drain;
  logic [7:0]  ram [4][8];
  // Buffer drains unless the engine is reading the same cycle
  always_comb
  begin
    drain   = (cnt_f_q != 2'h0) && (sie_buf_rd == 3'h0);
    fifo_d  = fifo_q;
    cnt_f_d = cnt_f_q;
    if (drain)
    begin
      fifo_d[0] = fifo_q[1];
      cnt_f_d   = cnt_f_q - 2'h1;
    end
    if (mem_wr_valid && mem_wr_ready)
    begin
      fifo_d[cnt_f_d[0]] = {mem_addr, mem_wdata};
      cnt_f_d            = cnt_f_d + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_f_q   <= 2'h0;
      fifo_q[0] <= 16'h0000;
      fifo_q[1] <= 16'h0000;
    end
    else if (clk_en)
    begin
      cnt_f_q <= cnt_f_d;
      fifo_q  <= fifo_d;
    end
  end

  // Memory array; blocks guarded regions while setup is pending
  logic [7:0] brd_q;
  logic       blk_q;
  always_ff @(posedge sys_clk)
  begin
    if (clk_en)
    begin
      if (drain && !(mode_q[0][uepr_pkg::BIT_SETUP] && hit_setup_guard(fifo_q[0][15:8])) &&
          fifo_q[0][15:8] >= uepr_pkg::BUF_A_LO)
        ram[buf_slot(fifo_q[0][15:8])][fifo_q[0][10:8]] <= fifo_q[0][7:0];
      brd_q <= ram[sie_buf_rd_addr[4:3]][sie_buf_rd_addr[2:0]];
    end
  end

  // Outputs registered; blocked flag and ready straight from flops
  logic rdy_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      blk_q <= 1'b0;
      rdy_q <= 1'b1;
    end
    else if (clk_en)
    begin
      blk_q <= drain && mode_q[0][uepr_pkg::BIT_SETUP] && hit_setup_guard(fifo_q[0][15:8]);
      rdy_q <= (cnt_f_d != 2'h2);
    end
  end

  // ----------------------------------------------------------------
  // Outputs to processor and engine
  // ----------------------------------------------------------------
  assign io_rdata        = rdata_q;
  assign mem_wr_ready    = rdy_q;
  assign mem_wr_blocked  = blk_q;
  assign sie_buf_rd_data = brd_q;
  assign sie_addr_en  = addr_q[uepr_pkg::BIT_ADDR_EN];
  assign sie_dev_addr = addr_q[6:0];
  assign sie_mode = {mode_q[2][3:0], mode_q[1][3:0], mode_q[0][3:0]};
  assign sie_in_count = {cnt_q[2][3:0], cnt_q[1][3:0], cnt_q[0][3:0]};
  assign sie_toggle = {cnt_q[2][7], cnt_q[1][7], cnt_q[0][7]};
endmodule : uepr_regs

//--- tb/uepr_eng_model.sv
// Behavioural bus engine driving the block's engine-side pins.
// Assumes the block's clock; every task starts on a rising edge.
`timescale 1ns/1ps
module uepr_eng_model (
  input  wire logic       sys_clk,
  output logic            sie_bus_reset,
  output logic            sie_setup_data,
  output logic            sie_ack_start,
  output logic      [2:0] sie_ack_done,
  output logic      [2:0] sie_tok_setup,
  output logic      [2:0] sie_tok_in,
  output logic      [2:0] sie_tok_out,
  output logic      [2:0] sie_rx_valid,
  output logic      [2:0] sie_buf_rd,
  output logic      [4:0] sie_buf_rd_addr,
  input  wire logic [7:0] sie_buf_rd_data
);
  // Idle pins
  initial {sie_bus_reset, sie_setup_data, sie_ack_start, sie_ack_done, sie_tok_setup,
    sie_tok_in, sie_tok_out, sie_rx_valid, sie_buf_rd, sie_buf_rd_addr} = '0;
  task bus_reset();
    @(posedge sys_clk) sie_bus_reset <= 1'b1;
    @(posedge sys_clk) sie_bus_reset <= 1'b0;
  endtask : bus_reset
  task setup0();
    @(posedge sys_clk) {sie_tok_setup, sie_rx_valid} <= 6'h09;
    @(posedge sys_clk) {sie_tok_setup, sie_rx_valid, sie_setup_data} <= 7'h01;
    @(posedge sys_clk) {sie_setup_data, sie_ack_start} <= 2'h1;
    @(posedge sys_clk) {sie_ack_start, sie_ack_done} <= 4'h1;
    @(posedge sys_clk) sie_ack_done <= 3'h0;
  endtask : setup0
  // IN token, slow or prompt ACK
  task in_xfer(input int ep, input int gap);
    @(posedge sys_clk) sie_tok_in <= 3'(1 << ep);
    @(posedge sys_clk) sie_tok_in <= 3'h0;
    repeat (gap) @(posedge sys_clk);
    sie_ack_done <= 3'(1 << ep);
    @(posedge sys_clk) sie_ack_done <= 3'h0;
  endtask : in_xfer
  // OUT token with its data-valid report, then ACK on the next cycle
  task out_xfer(input int ep, input logic v);
    @(posedge sys_clk) {sie_tok_out, sie_rx_valid} <= {3'(1 << ep), v ? 3'(1 << ep) : 3'h0};
    @(posedge sys_clk) {sie_tok_out, sie_rx_valid, sie_ack_done} <= {6'h00, 3'(1 << ep)};
    @(posedge sys_clk) sie_ack_done <= 3'h0;
  endtask : out_xfer
  // Engine reads hold off the buffer drain; address is scrambled when released
  task stall(input int n);
    @(posedge sys_clk) sie_buf_rd <= 3'h4;
    repeat (n) @(posedge sys_clk);
    sie_buf_rd <= 3'h0;
    sie_buf_rd_addr <= ~sie_buf_rd_addr;
  endtask : stall
  task brd(input logic [4:0] a, output logic [7:0] v);
    @(posedge sys_clk) {sie_buf_rd, sie_buf_rd_addr} <= {3'h1, a};
    @(posedge sys_clk) {sie_buf_rd, sie_buf_rd_addr} <= {3'h0, ~a};
    @(posedge sys_clk) v = sie_buf_rd_data;
  endtask : brd
endmodule : uepr_eng_model

//--- tb/uepr_regs_assertions.sv
// Port checker for the endpoint register block.
// Assumes one clock and an async active-high reset.
`timescale 1ns/1ps
module uepr_regs_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        sie_bus_reset,
  input wire logic        sie_addr_en,
  input wire logic [6:0]  sie_dev_addr,
  input wire logic [11:0] sie_mode,
  input wire logic [11:0] sie_in_count,
  input wire logic [2:0]  sie_toggle
);
  // ----
  // Properties
  // ----
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  addr_write_a: assert property (io_wr && clk_en && io_addr == 8'h10 && !sie_bus_reset
    |=> {sie_addr_en, sie_dev_addr} == $past(io_wdata)) else $error("address write lost");
  bus_reset_a: assert property (sie_bus_reset && clk_en && !io_wr
    |=> !sie_addr_en && sie_dev_addr == 7'h00) else $error("bus reset kept address");
  rdata_idle_a: assert property (clk_en && !io_rd |=> io_rdata == 8'h00)
    else $error("read data not idle");
  unmapped_rd_a: assert property (clk_en && io_rd && io_addr == 8'h20
    |=> io_rdata == 8'h00) else $error("unmapped read nonzero");
  ep1_mode_a: assert property (io_wr && clk_en && io_addr == 8'h14
    |=> {4'h0, sie_mode[7:4]} == ($past(io_wdata) & 8'h0F)) else $error("mode not passed");
  ep1_count_a: assert property (io_wr && clk_en && io_addr == 8'h13
    |=> {sie_toggle[1], 3'h0, sie_in_count[7:4]} == ($past(io_wdata) & 8'h8F))
    else $error("count not passed");
  ep_rsvd_a: assert property (io_rd && clk_en && io_addr == 8'h14
    |=> io_rdata[7:5] == 3'h0) else $error("reserved bits set");
  reset_vals_a: assert property ($fell(sys_rst) |-> sie_mode == 12'h000
    && sie_in_count == 12'h000 && !sie_addr_en) else $error("reset value wrong");
endmodule : uepr_regs_assertions
bind uepr_regs uepr_regs_assertions u_chk (.sys_clk, .sys_rst, .clk_en, .io_wr, .io_rd,
  .io_addr, .io_wdata, .io_rdata, .sie_bus_reset, .sie_addr_en, .sie_dev_addr, .sie_mode,
  .sie_in_count, .sie_toggle);

//--- tb/uepr_regs_tb_top.sv
// Self-checking bench for the endpoint register block.
// Assumes the engine model and the bound checker.
`timescale 1ns/1ps
module uepr_regs_tb_top;
  logic        sys_clk, sys_rst, clk_en, io_wr, io_rd, mem_wr_valid, mem_wr_ready;
  logic        mem_wr_blocked, sie_bus_reset, sie_setup_data, sie_ack_start, sie_addr_en;
  logic [7:0]  io_addr, io_wdata, io_rdata, mem_addr, mem_wdata, sie_buf_rd_data, d;
  logic [2:0]  sie_ack_done, sie_tok_setup, sie_tok_in, sie_rx_valid, sie_buf_rd, sie_toggle;
  logic [2:0]  sie_tok_out;
  logic [4:0]  sie_buf_rd_addr;
  logic [6:0]  sie_dev_addr;
  logic [11:0] sie_mode, sie_in_count;
  int          errors, n_tests, nblk, nstall;
  int          exp_r[32];
  int          q[$];
  uepr_regs DUT (.sys_clk, .sys_rst, .clk_en, .io_wr, .io_rd, .io_addr, .io_wdata, .io_rdata,
    .mem_wr_valid, .mem_wr_ready, .mem_addr, .mem_wdata, .mem_wr_blocked, .sie_bus_reset,
    .sie_setup_data, .sie_ack_start, .sie_ack_done, .sie_tok_setup, .sie_tok_in,
    .sie_tok_out, .sie_rx_valid, .sie_buf_rd, .sie_buf_rd_addr, .sie_buf_rd_data,
    .sie_addr_en, .sie_dev_addr, .sie_mode, .sie_in_count, .sie_toggle);
  uepr_eng_model eng (.sys_clk, .sie_bus_reset, .sie_setup_data, .sie_ack_start, .sie_ack_done,
    .sie_tok_setup, .sie_tok_in, .sie_tok_out, .sie_rx_valid, .sie_buf_rd, .sie_buf_rd_addr,
    .sie_buf_rd_data);
  // ----
  // Clock, monitors and tasks
  // ----
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    nblk += (mem_wr_blocked === 1'b1);
    nstall += (mem_wr_ready === 1'b0);
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task iow(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk) {io_wr, io_addr, io_wdata} <= {1'b1, a, v};
    @(posedge sys_clk) io_wr <= 1'b0;
  endtask : iow
  task rchk(input logic [7:0] a, input string nm);
    @(posedge sys_clk) {io_rd, io_addr} <= {1'b1, a};
    @(posedge sys_clk) io_rd <= 1'b0;
    @(posedge sys_clk) chk(nm, 8'(exp_r[a[4:0]]), io_rdata);
  endtask : rchk
  // Request held until ready is sampled high, with a bounded wait
  task mw(input logic [7:0] a, input logic [7:0] v);
    int i;
    i = 0;
    @(posedge sys_clk) {mem_wr_valid, mem_addr, mem_wdata} <= {1'b1, a, v};
    do
    begin
      @(posedge sys_clk);
      i++;
    end
    while (mem_wr_ready !== 1'b1 && i < 50);
    mem_wr_valid <= 1'b0;
    if (i >= 50)
    begin
      errors++;
      finish_test();
    end
  endtask : mw
  task finish_test();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Main sequence; exp_r mirrors the registers
  initial
  begin
    {sys_rst, clk_en, io_wr, io_rd, io_addr, io_wdata} = {2'h3, 18'h0};
    {mem_wr_valid, mem_addr, mem_wdata} = 17'h0;
    void'($urandom(32'h812ac0ba));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int a = 16; a < 24; a++) rchk(a == 23 ? 8'h20 : 8'(a), "reset");
    for (int a = 16; a < 23; a++)
    begin
      d = 8'($urandom);
      exp_r[a] = (a == 20 || a == 22) ? d & 8'h1F : d;
      iow(8'(a), d);
      if (a != 18) rchk(8'(a), "regs");
    end
    eng.bus_reset();
    exp_r[16] = 0;
    rchk(8'h10, "busrst");
    // Setup: writes refused, guarded buffer writes dropped
    eng.setup0();
    iow(8'h12, 8'h00);
    mw(8'hE0, 8'h55);
    mw(8'hF0, 8'h66);
    exp_r[18] |= 8'h90;
    exp_r[17] |= 8'h40;
    rchk(8'h11, "valid");
    rchk(8'h12, "setup");
    iow(8'h12, 8'h00);
    exp_r[18] = 0;
    rchk(8'h12, "unlock");
    chk("blocked", 8'h01, 8'(nblk));
    mw(8'hE3, 8'hAA);
    eng.brd(5'h1B, d);
    chk("bufE3", 8'hAA, d);
    eng.in_xfer(1, $urandom % 4);
    exp_r[20] |= 8'h10;
    rchk(8'h14, "ack1");
    eng.in_xfer(0, $urandom % 4);
    iow(8'h12, 8'h0F);
    exp_r[18] = 8'h50;
    rchk(8'h12, "lock");
    // OUT on the control and second data endpoints, random data-valid report on control, valid on the second
    d = 8'($urandom);
    eng.out_xfer(0, d[0]);
    exp_r[18] |= 8'h30;
    exp_r[17] = (exp_r[17] & 8'hBF) | (d[0] ? 8'h40 : 8'h00);
    rchk(8'h11, "valid0");
    rchk(8'h12, "out0");
    eng.out_xfer(2, 1'b1);
    exp_r[21] |= 8'h40;
    exp_r[22] |= 8'h10;
    rchk(8'h15, "valid2");
    rchk(8'h16, "out2");
    // Clock enable low must freeze the address register against a write
    @(posedge sys_clk) clk_en <= 1'b0;
    iow(8'h10, 8'hA5);
    @(posedge sys_clk) clk_en <= 1'b1;
    rchk(8'h10, "freeze");
    // Fill while the engine stalls the drain, then read back
    fork
      eng.stall(12);
      for (int i = 0; i < 4; i++)
      begin
        d = 8'($urandom);
        q.push_back(d);
        mw(8'hF8 + 8'(i), d);
      end
    join
    chk("stall", 8'h01, 8'(nstall > 0));
    for (int i = 0; i < 4; i++)
    begin
      eng.brd(5'(i), d);
      chk("bufF8", 8'(q.pop_front()), d);
    end
    finish_test();
  end
endmodule : uepr_regs_tb_top
